//--- src/pcg_pkg.sv
// Constants shared by the coding and integrity datapath of one lane.
// Assumes a single 10 MHz clock; the BER window cycle count is derived from it here.
`default_nettype none
package pcg_pkg;
	localparam int          CLK_PERIOD_NS     = 100;
	localparam int          BER_WINDOW_NS     = 125000;
	localparam int          BER_WINDOW_CYCLES = BER_WINDOW_NS / CLK_PERIOD_NS;
	localparam logic [5:0]  BER_LIMIT         = 6'h10;
	localparam logic signed [8:0] DISP_BOUND  = 9'sd96;
	localparam logic signed [8:0] WORD_BITS   = 9'sd67;
	localparam logic [1:0]  SH_DATA           = 2'h1;
	localparam logic [1:0]  SH_CTRL           = 2'h2;
	localparam logic [7:0]  TYPE_IDLE         = 8'h1E;
	localparam logic [7:0]  TYPE_START        = 8'h78;
	localparam logic [63:0] TERM_TYPES        = 64'hFFE1D2CCB4AA9987;
	localparam logic [7:0]  CHAR_IDLE         = 8'h07;
	localparam logic [7:0]  CHAR_START        = 8'hFB;
	localparam logic [7:0]  CHAR_TERM         = 8'hFD;
	localparam logic [7:0]  CHAR_ERR          = 8'hFE;
	localparam logic [6:0]  CODE_ERR          = 7'h1E;
	localparam logic [31:0] CRC_INIT          = 32'hFFFFFFFF;
	localparam logic [57:0] SCR_RESET         = 58'h3FFFFFFFFFFFFFF;
	localparam logic [42:0] SEED_FILL         = 43'h7FFFFFFFFFF;
	localparam logic [15:0] CNT_RESET         = 16'h0000;
	localparam logic signed [8:0] RD_RESET    = 9'sd0;
	typedef enum logic {ENC_IDLE, ENC_DATA} pcg_enc_t;
	typedef enum logic {DEC_INIT, DEC_NORMAL} pcg_dec_t;
endpackage
`default_nettype wire

//--- src/pcg_buffer.sv
// Small FIFO of flip-flops with valid and ready on both sides.
// Assumes DEPTH is a power of two so the pointers wrap naturally.
`timescale 1ns/1ps
`default_nettype none
module pcg_buffer #(
	parameter int WIDTH = 73,
	parameter int DEPTH = 2
) (
	input  wire logic             clk_in,
	input  wire logic             reset_in,
	input  wire logic             ce_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	input  wire logic             in_valid_in,
	output logic                  in_ready_out,
	output logic      [WIDTH-1:0] out_data_out,
	output logic                  out_valid_out,
	input  wire logic             out_ready_in
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [CW-1:0]    cnt_q;
	logic             push;
	logic             pop;
	logic [CW-1:0]    cnt_d;

	assign push = ce_in && in_valid_in && in_ready_out;
	assign pop = ce_in && out_valid_out && out_ready_in;
	assign out_data_out = mem_q[rd_q];

	always_comb begin
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + CW'(1);
		end else if (pop && !push) begin
			cnt_d = cnt_q - CW'(1);
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			in_ready_out <= 1'b0;
			out_valid_out <= 1'b0;
		end else begin
			if (push) begin
				wr_q <= wr_q + AW'(1);
			end
			if (pop) begin
				rd_q <= rd_q + AW'(1);
			end
			cnt_q <= cnt_d;
			in_ready_out <= (cnt_d != CW'(DEPTH));
			out_valid_out <= (cnt_d != '0);
		end
	end

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_q[wr_q] <= in_data_in;
		end
	end
endmodule
`default_nettype wire

//--- src/pcg_scrambler.sv
// Scrambler or descrambler for x^58 + x^39 + 1, 64 bits per step.
// Bit 0 of the data is the first bit on the line; the caller sets adv_in.
`timescale 1ns/1ps
`default_nettype none
module pcg_scrambler #(
	parameter int W = 64
) (
	input  wire logic         clk_in,
	input  wire logic         reset_in,
	input  wire logic         ce_in,
	input  wire logic         descramble_in,
	input  wire logic         sync_mode_in,
	input  wire logic         load_in,
	input  wire logic [57:0]  seed_in,
	input  wire logic         adv_in,
	input  wire logic [W-1:0] data_in,
	output logic      [W-1:0] data_out
);
	import pcg_pkg::*;
	logic [57:0] state_q;
	logic [57:0] state_d;

	always_comb begin
		logic fb;
		logic ob;
		fb = 1'b0;
		ob = 1'b0;
		state_d = state_q;
		data_out = '0;
		for (int i = 0; i < W; i++) begin
			fb = state_d[38] ^ state_d[57];
			ob = data_in[i] ^ fb;
			data_out[i] = ob;
			if (sync_mode_in) begin
				state_d = {state_d[56:0], fb};
			end else if (descramble_in) begin
				state_d = {state_d[56:0], data_in[i]};
			end else begin
				state_d = {state_d[56:0], ob};
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state_q <= SCR_RESET;
		end else if (ce_in && load_in) begin
			state_q <= seed_in;
		end else if (ce_in && adv_in) begin
			state_q <= state_d;
		end
	end
endmodule
`default_nettype wire

//--- src/pcg_top.sv
// One lane of 10G coding: 64b/66b, scrambling, Interlaken CRC and
// disparity, 10GBASE-R BER monitor. Parallel side is fabric logic;
// the 67-bit lane words come from and go to an aligned gearbox.
//
// What this block does
// - CRC-32 covers the whole metaframe, diagnostic word included.
// - Transmit CRC is written into the diagnostic word's CRC field.
// - Receive CRC mismatch on a metaframe raises the lane CRC error flag.
// - Invalid headers count only after block lock, per 125 us window.
// - More than 16 invalid headers in a window raise high BER.
// - BER count clear zeroes the invalid-header counter, 10GBASE-R only.
// - Errored-block clear zeroes its counter, 10GBASE-R only.
// - Encoder turns 64-bit data and 8 control bits into 66-bit blocks.
// - In 10GBASE-R, the transmit state machine checks words and enforces legal block order.
// - Decoder turns descrambled 66-bit blocks into data and control bits.
// - In 10GBASE-R, high BER forces error blocks and sends the receive state machine back to DEC_INIT.
// - Scrambler and descrambler use x^58 + x^39 + 1.
// - Interlaken scrambles synchronously, 10GBASE-R self-synchronously.
// - Transmit running disparity stays within plus or minus 96.
// - Bit 66 of each transmit word tells whether it was inverted.
// - In Interlaken, receive words with bit 66 set have bits 63 to 0 inverted back.
// - Block lock rises after a set number of valid sync headers.
`timescale 1ns/1ps
`default_nettype none
module pcg_top #(
	parameter int          LOCK_HEADERS = 64,
	parameter logic [31:0] CRC_POLY     = 32'h04C11DB7
) (
	input  wire logic        sys_clk_in,
	input  wire logic        reset_in,
	input  wire logic        ce_in,
	input  wire logic        mode_ilk_in,
	input  wire logic [14:0] tx_seed_in,
	input  wire logic        seed_load_in,
	input  wire logic [63:0] tx_data_in,
	input  wire logic [7:0]  tx_ctrl_in,
	input  wire logic        tx_diag_in,
	input  wire logic        tx_valid_in,
	output logic             tx_ready_out,
	output logic      [66:0] tx_word_out,
	output logic             tx_valid_out,
	input  wire logic        tx_lane_ready_in,
	input  wire logic [66:0] rx_word_in,
	input  wire logic        rx_valid_in,
	input  wire logic        rx_diag_in,
	output logic      [63:0] rx_data_out,
	output logic      [7:0]  rx_ctrl_out,
	output logic             rx_valid_out,
	output logic             block_lock_flag_out,
	output logic             high_ber_flag_out,
	output logic             lane_crc_error_flag_out,
	output logic             descrambler_error_flag_out,
	input  wire logic        ber_count_clear_in,
	input  wire logic        errored_block_count_clear_in,
	output logic      [15:0] ber_count_out,
	output logic      [15:0] errored_block_count_out
);
	import pcg_pkg::*;

	function automatic logic [31:0] crc64(input logic [31:0] c,
			input logic [63:0] d);
		logic [31:0] r;
		r = c;
		for (int i = 63; i >= 0; i--) begin
			r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? CRC_POLY : 32'h0);
		end
		return r;
	endfunction

	function automatic logic [6:0] ones(input logic [66:0] w);
		logic [6:0] n;
		n = '0;
		for (int i = 0; i < 67; i++) begin
			n = n + 7'(w[i]);
		end
		return n;
	endfunction

	localparam logic [63:0] ERR_PAY = {{8{CODE_ERR}}, TYPE_IDLE};

	// Transmit side: buffer, encoder, CRC, scrambler, disparity.
	logic [72:0] buf_data;
	logic        buf_valid;
	logic        tx_pop;
	logic [63:0] b_data;
	logic [7:0]  b_ctrl;
	logic        b_diag;
	pcg_enc_t    enc_q;
	pcg_enc_t    enc_d;
	logic [1:0]  enc_hdr;
	logic [63:0] enc_pay;
	logic [63:0] crc_word;
	logic [31:0] tx_crc_q;
	logic [63:0] scr_out;
	logic signed [8:0] rd_q;
	logic signed [8:0] dw;
	logic signed [8:0] dw_inv;
	logic        do_inv;

	assign tx_pop = ce_in && buf_valid && (tx_lane_ready_in || !tx_valid_out);
	assign {b_diag, b_ctrl, b_data} = buf_data;

	pcg_buffer #(.WIDTH(73), .DEPTH(2)) u_txbuf (
		.clk_in        (sys_clk_in),
		.reset_in      (reset_in),
		.ce_in         (ce_in),
		.in_data_in    ({tx_diag_in, tx_ctrl_in, tx_data_in}),
		.in_valid_in   (tx_valid_in),
		.in_ready_out  (tx_ready_out),
		.out_data_out  (buf_data),
		.out_valid_out (buf_valid),
		.out_ready_in  (tx_pop)
	);

	always_comb begin
		logic        th;
		logic [63:0] tp;
		logic [63:0] m;
		th = 1'b0;
		tp = '0;
		m = '0;
		for (int k = 0; k < 8; k++) begin
			m = ~({64{1'b1}} << (8 * k));
			if (b_ctrl == 8'(8'hFF << k) && b_data[8*k +: 8] == CHAR_TERM) begin
				th = 1'b1;
				tp = ((b_data & m) << 8) | {56'h0, TERM_TYPES[8*k +: 8]};
			end
		end
		enc_d = enc_q;
		enc_hdr = SH_CTRL;
		enc_pay = ERR_PAY;
		if (mode_ilk_in) begin
			enc_hdr = (b_ctrl != 8'h00) ? SH_CTRL : SH_DATA;
			enc_pay = b_data;
		end else if (b_ctrl == 8'h00) begin
			if (enc_q == ENC_DATA) begin
				enc_hdr = SH_DATA;
				enc_pay = b_data;
			end
		end else if (b_ctrl == 8'h01 && b_data[7:0] == CHAR_START) begin
			if (enc_q == ENC_IDLE) begin
				enc_pay = {b_data[63:8], TYPE_START};
				enc_d = ENC_DATA;
			end else begin
				enc_d = ENC_IDLE;
			end
		end else if (th && enc_q == ENC_DATA) begin
			enc_pay = tp;
			enc_d = ENC_IDLE;
		end else if (b_ctrl == 8'hFF && b_data == {8{CHAR_IDLE}}
				&& enc_q == ENC_IDLE) begin
			enc_pay = {56'h0, TYPE_IDLE};
		end else begin
			enc_d = ENC_IDLE;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			enc_q <= ENC_IDLE;
		end else if (tx_pop) begin
			enc_q <= enc_d;
		end
	end

	// The CRC field reads as zero while the metaframe's CRC is taken.
	always_comb begin
		crc_word = enc_pay;
		if (b_diag) begin
			crc_word[31:0] = crc64(tx_crc_q, {enc_pay[63:32], 32'h0});
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			tx_crc_q <= CRC_INIT;
		end else if (tx_pop && mode_ilk_in) begin
			tx_crc_q <= b_diag ? CRC_INIT : crc64(tx_crc_q, enc_pay);
		end
	end

	pcg_scrambler #(.W(64)) u_scr (
		.clk_in        (sys_clk_in),
		.reset_in      (reset_in),
		.ce_in         (ce_in),
		.descramble_in (1'b0),
		.sync_mode_in  (mode_ilk_in),
		.load_in       (seed_load_in),
		.seed_in       ({SEED_FILL, tx_seed_in}),
		.adv_in        (tx_pop),
		.data_in       (mode_ilk_in ? crc_word : enc_pay),
		.data_out      (scr_out)
	);

	assign dw = $signed({1'b0, ones({1'b0, enc_hdr, scr_out}), 1'b0}) - WORD_BITS;
	assign dw_inv = $signed({1'b0, ones({1'b1, enc_hdr, ~scr_out}), 1'b0})
		- WORD_BITS;
	assign do_inv = mode_ilk_in && ((rd_q > 0 && dw > 0) || (rd_q < 0 && dw < 0));

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			rd_q <= RD_RESET;
			tx_word_out <= '0;
			tx_valid_out <= 1'b0;
		end else if (ce_in) begin
			if (tx_pop) begin
				tx_valid_out <= 1'b1;
				if (do_inv) begin
					tx_word_out <= {1'b1, enc_hdr, ~scr_out};
					rd_q <= rd_q + dw_inv;
				end else begin
					tx_word_out <= {1'b0, enc_hdr, scr_out};
					if (mode_ilk_in) begin
						rd_q <= rd_q + dw;
					end
				end
			end else if (tx_lane_ready_in) begin
				tx_valid_out <= 1'b0;
			end
		end
	end

	// Receive side: bit-66 inversion undo, descramble, CRC check, decode, BER.
	logic        rx_take;
	logic [1:0]  rx_hdr;
	logic        hdr_ok;
	logic [63:0] dsc_in;
	logic [63:0] dsc_out;
	logic [31:0] rx_crc_q;
	logic        crc_bad;
	pcg_dec_t    dec_q;
	pcg_dec_t    dec_d;
	logic [63:0] dec_data;
	logic [7:0]  dec_ctrl;
	logic        dec_err;
	logic [7:0]  lock_cnt_q;
	logic        sh_err;
	logic [5:0]  ber_win_q;
	logic [10:0] win_q;
	logic        win_end;

	assign rx_take = ce_in && rx_valid_in;
	assign rx_hdr = rx_word_in[65:64];
	assign hdr_ok = (rx_hdr == SH_DATA) || (rx_hdr == SH_CTRL);
	assign dsc_in = (mode_ilk_in && rx_word_in[66]) ? ~rx_word_in[63:0]
		: rx_word_in[63:0];

	pcg_scrambler #(.W(64)) u_dsc (
		.clk_in        (sys_clk_in),
		.reset_in      (reset_in),
		.ce_in         (ce_in),
		.descramble_in (1'b1),
		.sync_mode_in  (mode_ilk_in),
		.load_in       (seed_load_in),
		.seed_in       ({SEED_FILL, tx_seed_in}),
		.adv_in        (rx_take),
		.data_in       (dsc_in),
		.data_out      (dsc_out)
	);

	assign crc_bad = crc64(rx_crc_q, {dsc_out[63:32], 32'h0}) != dsc_out[31:0];

	always_comb begin
		logic [63:0] m;
		m = '0;
		dec_d = dec_q;
		dec_data = {8{CHAR_ERR}};
		dec_ctrl = 8'hFF;
		dec_err = 1'b1;
		if (mode_ilk_in) begin
			dec_data = dsc_out;
			dec_ctrl = (rx_hdr == SH_CTRL) ? 8'hFF : 8'h00;
			dec_err = !hdr_ok;
		end else if (high_ber_flag_out) begin
			dec_err = 1'b1;
		end else if (rx_hdr == SH_DATA && dec_q == DEC_NORMAL) begin
			dec_data = dsc_out;
			dec_ctrl = 8'h00;
			dec_err = 1'b0;
		end else if (rx_hdr == SH_CTRL) begin
			if (dsc_out[7:0] == TYPE_IDLE && dsc_out[63:8] == 56'h0) begin
				dec_data = {8{CHAR_IDLE}};
				dec_err = 1'b0;
				dec_d = DEC_NORMAL;
			end else if (dsc_out[7:0] == TYPE_START && dec_q == DEC_NORMAL) begin
				dec_data = {dsc_out[63:8], CHAR_START};
				dec_ctrl = 8'h01;
				dec_err = 1'b0;
			end
			for (int k = 0; k < 8; k++) begin
				m = {64{1'b1}} << (8 * k);
				if (dsc_out[7:0] == TERM_TYPES[8*k +: 8] && dec_q == DEC_NORMAL) begin
					dec_data = ((dsc_out >> 8) & ~m) | ({8{CHAR_IDLE}} & (m << 8))
						| (64'(CHAR_TERM) << (8 * k));
					dec_ctrl = 8'(8'hFF << k);
					dec_err = 1'b0;
				end
			end
		end
		if (dec_err && !mode_ilk_in) begin
			dec_d = DEC_INIT;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			dec_q <= DEC_INIT;
			rx_data_out <= '0;
			rx_ctrl_out <= '0;
			rx_valid_out <= 1'b0;
		end else if (ce_in) begin
			rx_valid_out <= rx_valid_in;
			if (rx_valid_in) begin
				dec_q <= dec_d;
				rx_data_out <= dec_data;
				rx_ctrl_out <= dec_ctrl;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			rx_crc_q <= CRC_INIT;
			lane_crc_error_flag_out <= 1'b0;
		end else if (rx_take && mode_ilk_in) begin
			if (rx_diag_in) begin
				rx_crc_q <= CRC_INIT;
				lane_crc_error_flag_out <= crc_bad;
			end else begin
				rx_crc_q <= crc64(rx_crc_q, dsc_out);
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			lock_cnt_q <= '0;
			block_lock_flag_out <= 1'b0;
		end else if (rx_take && !block_lock_flag_out) begin
			if (!hdr_ok) begin
				lock_cnt_q <= '0;
			end else if (lock_cnt_q == 8'(LOCK_HEADERS - 1)) begin
				block_lock_flag_out <= 1'b1;
			end else begin
				lock_cnt_q <= lock_cnt_q + 8'h01;
			end
		end
	end

	assign sh_err = rx_take && block_lock_flag_out && !hdr_ok;
	assign win_end = ce_in && block_lock_flag_out
		&& win_q == 11'(BER_WINDOW_CYCLES - 1);

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			win_q <= '0;
			ber_win_q <= '0;
			high_ber_flag_out <= 1'b0;
			descrambler_error_flag_out <= 1'b0;
		end else if (ce_in) begin
			descrambler_error_flag_out <= sh_err;
			if (!block_lock_flag_out) begin
				win_q <= '0;
				ber_win_q <= '0;
			end else if (win_end) begin
				// An error in the last cycle belongs to the window that ends.
				win_q <= '0;
				ber_win_q <= '0;
			end else begin
				win_q <= win_q + 11'h001;
				if (sh_err && ber_win_q != 6'h3F) begin
					ber_win_q <= ber_win_q + 6'h01;
				end
			end
			if (sh_err && ber_win_q >= BER_LIMIT) begin
				high_ber_flag_out <= 1'b1;
			end else if (win_end && ber_win_q <= BER_LIMIT) begin
				high_ber_flag_out <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			ber_count_out <= CNT_RESET;
			errored_block_count_out <= CNT_RESET;
		end else if (ce_in) begin
			if (ber_count_clear_in && !mode_ilk_in) begin
				ber_count_out <= CNT_RESET;
			end else if (sh_err && ber_count_out != 16'hFFFF) begin
				ber_count_out <= ber_count_out + 16'h0001;
			end
			if (errored_block_count_clear_in && !mode_ilk_in) begin
				errored_block_count_out <= CNT_RESET;
			end else if (rx_take && dec_err && !mode_ilk_in
					&& errored_block_count_out != 16'hFFFF) begin
				errored_block_count_out <= errored_block_count_out + 16'h0001;
			end
		end
	end

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);

	sequence s_diag_word;
		rx_take && mode_ilk_in && rx_diag_in;
	endsequence
	sequence s_clean_end;
		win_end && ber_win_q <= BER_LIMIT && !sh_err;
	endsequence

	property p_crc_err;
		s_diag_word ##0 crc_bad |=> lane_crc_error_flag_out;
	endproperty
	a_crc_err: assert property (p_crc_err) else $error("crc flag missed");
	property p_no_count_unlocked;
		!block_lock_flag_out && !ber_count_clear_in |=> $stable(ber_count_out);
	endproperty
	a_no_count_unlocked: assert property (p_no_count_unlocked)
		else $error("ber counted before lock");
	property p_ber_high;
		sh_err && ber_win_q == BER_LIMIT |=> high_ber_flag_out[*2];
	endproperty
	a_ber_high: assert property (p_ber_high) else $error("high ber missed");
	property p_ber_clr;
		ce_in && ber_count_clear_in && !mode_ilk_in |=> ber_count_out == 16'h0;
	endproperty
	a_ber_clr: assert property (p_ber_clr) else $error("ber clear failed");
	property p_eb_clr;
		ce_in && errored_block_count_clear_in && !mode_ilk_in
			|=> errored_block_count_out == 16'h0;
	endproperty
	a_eb_clr: assert property (p_eb_clr) else $error("eb clear failed");
	property p_disp;
		rd_q <= DISP_BOUND && rd_q >= -DISP_BOUND;
	endproperty
	a_disp: assert property (p_disp) else $error("disparity out of bound");
	property p_no_inv_10g;
		tx_pop && !mode_ilk_in |=> !tx_word_out[66] && tx_valid_out;
	endproperty
	a_no_inv_10g: assert property (p_no_inv_10g) else $error("bad bit 66");
	property p_ber_clean;
		s_clean_end |=> !high_ber_flag_out && win_q == 11'h0;
	endproperty
	a_ber_clean: assert property (p_ber_clean) else $error("high ber stuck");
	property p_lock_stays;
		block_lock_flag_out |=> block_lock_flag_out;
	endproperty
	a_lock_stays: assert property (p_lock_stays) else $error("lock dropped");
endmodule
`default_nettype wire

//--- testbench/pcg_lane_model.sv
// Lane-side model: accepts transmit words with a stall pattern and loops
// them back as receive words, or passes words supplied by the bench.
`timescale 1ns/1ps
`default_nettype none
module pcg_lane_model (
	input  wire logic        clk_in,
	input  wire logic        reset_in,
	input  wire logic        loop_en_in,
	input  wire logic        slow_in,
	input  wire logic [7:0]  flip_idx_in,
	input  wire logic [66:0] tx_word_in,
	input  wire logic        tx_valid_in,
	output logic             lane_ready_out,
	input  wire logic [66:0] tb_word_in,
	input  wire logic        tb_valid_in,
	output logic      [66:0] rx_word_out,
	output logic             rx_valid_out,
	output logic             rx_diag_out
);
	logic [2:0]  cnt_q;
	logic [7:0]  n_q;
	logic [66:0] held_q;
	logic        took_q;
	logic        diag_q;
	logic [66:0] lw_q;
	logic        lv_q;
	logic        ld_q;
	// Bench words pass straight through, so only the bench sets their timing.
	assign rx_word_out = loop_en_in ? lw_q : tb_word_in;
	assign rx_valid_out = loop_en_in ? lv_q : tb_valid_in;
	assign rx_diag_out = loop_en_in && ld_q;
	always @(posedge clk_in) begin
		cnt_q <= reset_in ? 3'h0 : cnt_q + 3'h1;
		lane_ready_out <= !reset_in && (slow_in ? cnt_q == 3'h0 : cnt_q != 3'h3);
		took_q <= !reset_in && tx_valid_in && lane_ready_out;
		if (reset_in) begin
			n_q <= 8'h00;
		end else if (tx_valid_in && lane_ready_out) begin
			// One payload bit is flipped on the chosen word to spoil its frame.
			held_q <= tx_word_in ^ ((n_q == flip_idx_in) ? 67'h20 : 67'h0);
			diag_q <= n_q[2:0] == 3'h7;
			n_q <= n_q + 8'h01;
		end
	end
	always @(negedge clk_in) begin
		if (took_q) begin
			lw_q <= held_q;
			lv_q <= 1'b1;
			ld_q <= diag_q;
		end else begin
			lw_q <= ~lw_q;
			lv_q <= 1'b0;
			ld_q <= 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- testbench/tb_pcg_top.sv
// Self-checking bench for one coding lane: Interlaken loopback, then
// 10GBASE-R receive words driven directly for lock and error monitoring.
`timescale 1ns/1ps
`default_nettype none
module tb_pcg_top;
	import pcg_pkg::*;
	logic sys_clk_in, reset_in, ce_in, mode_ilk_in, seed_load_in;
	logic [14:0] tx_seed_in;
	logic [63:0] tx_data_in, rx_data_out;
	logic [7:0] tx_ctrl_in, rx_ctrl_out, flip_idx;
	logic tx_diag_in, tx_valid_in, tx_ready_out, tx_valid_out, tx_lane_ready_in;
	logic [66:0] tx_word_out, rx_word_in, tb_word;
	logic rx_valid_in, rx_diag_in, rx_valid_out, tb_valid, loop_en, slow;
	logic block_lock_flag_out, high_ber_flag_out, lane_crc_error_flag_out;
	logic descrambler_error_flag_out, ber_count_clear_in;
	logic errored_block_count_clear_in;
	logic [15:0] ber_count_out, errored_block_count_out;
	logic [63:0] ed[64];
	logic [7:0] ec[64];
	int seed, n_errors, tests_run, ti, ri, rd, refused, cyc, i;

	pcg_top #(.LOCK_HEADERS(4)) dut (.sys_clk_in(sys_clk_in),
		.reset_in(reset_in), .ce_in(ce_in), .mode_ilk_in(mode_ilk_in),
		.tx_seed_in(tx_seed_in), .seed_load_in(seed_load_in),
		.tx_data_in(tx_data_in), .tx_ctrl_in(tx_ctrl_in),
		.tx_diag_in(tx_diag_in), .tx_valid_in(tx_valid_in),
		.tx_ready_out(tx_ready_out), .tx_word_out(tx_word_out),
		.tx_valid_out(tx_valid_out), .tx_lane_ready_in(tx_lane_ready_in),
		.rx_word_in(rx_word_in), .rx_valid_in(rx_valid_in),
		.rx_diag_in(rx_diag_in), .rx_data_out(rx_data_out),
		.rx_ctrl_out(rx_ctrl_out), .rx_valid_out(rx_valid_out),
		.block_lock_flag_out(block_lock_flag_out),
		.high_ber_flag_out(high_ber_flag_out),
		.lane_crc_error_flag_out(lane_crc_error_flag_out),
		.descrambler_error_flag_out(descrambler_error_flag_out),
		.ber_count_clear_in(ber_count_clear_in),
		.errored_block_count_clear_in(errored_block_count_clear_in),
		.ber_count_out(ber_count_out),
		.errored_block_count_out(errored_block_count_out));
	pcg_lane_model lane (.clk_in(sys_clk_in), .reset_in(reset_in),
		.loop_en_in(loop_en), .slow_in(slow), .flip_idx_in(flip_idx),
		.tx_word_in(tx_word_out), .tx_valid_in(tx_valid_out),
		.lane_ready_out(tx_lane_ready_in), .tb_word_in(tb_word),
		.tb_valid_in(tb_valid), .rx_word_out(rx_word_in),
		.rx_valid_out(rx_valid_in), .rx_diag_out(rx_diag_in));

	initial begin
		sys_clk_in = 1'b0;
		forever #50 sys_clk_in = ~sys_clk_in;
	end

	task automatic chk(input logic [63:0] g, input logic [63:0] e);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task test_done;
		$display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// Leaves valid high so that writes can follow back to back.
	task automatic put(input logic [63:0] d, input logic [7:0] c, input logic g);
		int k;
		tx_data_in = d;
		tx_ctrl_in = c;
		tx_diag_in = g;
		tx_valid_in = 1'b1;
		k = 0;
		while (tx_ready_out !== 1'b1 && k < 200) begin
			@(negedge sys_clk_in);
			k++;
			refused++;
		end
		@(negedge sys_clk_in);
	endtask

	task automatic rxw(input logic [1:0] h);
		tb_word = {1'b0, h, $random(seed), $random(seed)};
		tb_valid = 1'b1;
		@(negedge sys_clk_in);
	endtask

	always @(negedge sys_clk_in) begin
		if (loop_en && tx_valid_out === 1'b1 && tx_lane_ready_in === 1'b1) begin
			chk(tx_word_out[65:64], ec[ti] != 8'h00 ? SH_CTRL : SH_DATA);
			rd += 2 * $countones(tx_word_out) - 67;
			chk(rd > 96 || rd < -96, 0);
			ti++;
		end
		if (!loop_en && tx_valid_out === 1'b1 && tx_lane_ready_in === 1'b1) begin
			chk(tx_word_out[65:64], ti == 2 ? SH_DATA : SH_CTRL);
			ti++;
		end
		if (loop_en && rx_valid_out === 1'b1) begin
			if (ri % 8 == 7) begin
				chk(lane_crc_error_flag_out, ri == 31);
			end else begin
				chk(rx_data_out, ed[ri]);
				chk(rx_ctrl_out, ec[ri] != 8'h00 ? 8'hFF : 8'h00);
			end
			ri++;
		end
	end

	always @(posedge sys_clk_in) begin
		cyc++;
		if (cyc == 10000) begin
			n_errors++;
			test_done();
		end
	end

	initial begin
		{reset_in, mode_ilk_in, loop_en, ce_in} = 4'hF;
		{seed_load_in, tx_diag_in, tx_valid_in, tb_valid, slow} = 5'h0;
		{ber_count_clear_in, errored_block_count_clear_in} = 2'h0;
		{tx_seed_in, tx_data_in, tx_ctrl_in, tb_word} = '0;
		flip_idx = 8'd31;
		{n_errors, tests_run, ti, ri, rd, refused, cyc} = '0;
		seed = 43;
		repeat (2) @(negedge sys_clk_in);
		reset_in = 1'b0;
		tx_seed_in = 15'($random(seed));
		seed_load_in = 1'b1;
		@(negedge sys_clk_in);
		seed_load_in = 1'b0;
		for (i = 0; i < 64; i++) begin
			slow = i >= 24 && i < 40;
			ed[i] = {$random(seed), $random(seed)};
			ec[i] = (i % 3 == 0) ? 8'h00 : 8'($random(seed));
			put(ed[i], ec[i], i % 8 == 7);
		end
		tx_valid_in = 1'b0;
		for (i = 0; i < 300 && ri < 64; i++) @(negedge sys_clk_in);
		chk(ri, 64);
		chk(refused > 0, 1);
		// Lock is sticky, so a second reset lets 10GBASE-R relearn it.
		loop_en = 1'b0;
		mode_ilk_in = 1'b0;
		reset_in = 1'b1;
		ti = 0;
		repeat (2) @(negedge sys_clk_in);
		reset_in = 1'b0;
		put({$random(seed), $random(seed)}, 8'h00, 1'b0);
		put({24'($random(seed)), $random(seed), CHAR_START}, 8'h01, 1'b0);
		put({$random(seed), $random(seed)}, 8'h00, 1'b0);
		put({{7{CHAR_IDLE}}, CHAR_TERM}, 8'hFF, 1'b0);
		put({$random(seed), $random(seed)}, 8'h00, 1'b0);
		tx_valid_in = 1'b0;
		repeat (8) @(negedge sys_clk_in);
		chk(ti, 5);
		rxw(2'h0);
		chk(ber_count_out, 0);
		repeat (4) rxw(SH_CTRL);
		chk(block_lock_flag_out, 1);
		for (i = 1; i <= 17; i++) begin
			rxw(2'h3);
			chk(descrambler_error_flag_out, 1);
			chk(ber_count_out, i);
			chk(high_ber_flag_out, i > 16);
		end
		rxw(SH_CTRL);
		chk({rx_ctrl_out, rx_data_out}, {8'hFF, {8{CHAR_ERR}}});
		tb_valid = 1'b0;
		chk(errored_block_count_out != 16'h0000, 1);
		ber_count_clear_in = 1'b1;
		errored_block_count_clear_in = 1'b1;
		@(negedge sys_clk_in);
		{ber_count_clear_in, errored_block_count_clear_in} = 2'h0;
		chk(ber_count_out, 0);
		chk(errored_block_count_out, 0);
		repeat (2600) @(negedge sys_clk_in);
		chk(high_ber_flag_out, 0);
		test_done();
	end
endmodule
`default_nettype wire
